// *** idw_pkg.sv ***
package idw_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam int          IDW_AW       = 8;
  localparam logic [7:0]  IDW_OFF_CTRL = 8'h00;
  localparam logic [7:0]  IDW_OFF_STAT = 8'h1C;
  localparam int          IDW_NCFG     = 7;
  localparam logic [2:0]  IDW_STAT_IDX = 3'h7;
  // writable bits of each config word, reset value is zero
  localparam logic [31:0] IDW_CFG_MASK [IDW_NCFG] = '{
    32'h0000000F, 32'h000000F7, 32'h0000FFFF, 32'hFFFF00FF,
    32'h0000003F, 32'h00003FFF, 32'h0000FFFF};
  localparam logic [31:0] IDW_CFG_RST  = 32'h00000000;
  localparam logic [1:0]  IDW_RESP_OK  = 2'h0;
  localparam logic [1:0]  IDW_RESP_ERR = 2'h2;

  // ==========================================
  // field positions
  localparam int IDW_CTRL_DEV1   = 0;
  localparam int IDW_CTRL_SIG    = 1;
  localparam int IDW_CTRL_MWDMA  = 2;
  localparam int IDW_CTRL_MSN    = 3;
  localparam int IDW_UDMA_SELEN  = 7;
  localparam int IDW_NUDMA       = 5;

  // ==========================================
  // identify word indices and constants
  localparam logic [7:0]  IDW_W_UDMA  = 8'h58;
  localparam logic [7:0]  IDW_W_ERN   = 8'h59;
  localparam logic [7:0]  IDW_W_ERE   = 8'h5A;
  localparam logic [7:0]  IDW_W_APM   = 8'h5B;
  localparam logic [7:0]  IDW_W_MREV  = 8'h5C;
  localparam logic [7:0]  IDW_W_HWT   = 8'h5D;
  localparam logic [7:0]  IDW_W_MSN   = 8'h7F;
  localparam logic [7:0]  IDW_W_SEC   = 8'h80;
  localparam logic [7:0]  IDW_W_CARD  = 8'hA0;
  localparam logic [7:0]  IDW_W_LAST  = 8'hFE;
  localparam logic [7:0]  IDW_W_INTEG = 8'hFF;
  localparam logic [7:0]  IDW_SIGNATURE = 8'hA5;
  localparam int          IDW_HWT_CBL = 13;

  typedef struct packed {
    logic enh_erase;
    logic max_lvl;
    logic frozen;
    logic locked;
    logic enabled;
    logic supported;
  } idw_sec_t;

  typedef enum logic [2:0] {
    IDW_CS_IDLE = 3'b001,
    IDW_CS_SUM  = 3'b010,
    IDW_CS_DONE = 3'b100
  } idw_cs_t;
endpackage

// *** idw_top.sv ***
// How it works
// R1: ultra and multiword DMA never both selected
// R2: selected-mode bits 12..8 at most one
// R3: bits 15..13 and 7..5 read zero
// R4: supported bits form run from bit 0
// R5: no mode-0 support clears whole word
// R6: normal erase time byte passed unchanged
// R7: enhanced erase time byte passed unchanged
// R8: power level in low byte
// R9: master password revision word as stored
// R10: reset results placed by device number
// R11: cable level sampled into bit 13
// R12: media status word only bit 0
// R13: level bit only when enabled at maximum
// R14: bit 5 shows enhanced erase support
// R15: expired count aborts until hardware reset
// R16: frozen locked enabled supported in bits 3..0
// R17: card mode bits 13 and 12
// R18: card current in bits 11..0
// R19: signature A5 gates checksum byte
// R20: checksum is negated byte sum
// R21: reserved bits and words read zero
// R22: checksum only after words settle
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
module idw_top (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   s_axi_awvalid_i,
  output logic                        s_axi_awready_o,
  input  wire logic [idw_pkg::IDW_AW-1:0] s_axi_awaddr_i,
  input  wire logic                   s_axi_wvalid_i,
  output logic                        s_axi_wready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  output logic [1:0]                  s_axi_bresp_o,
  input  wire logic                   s_axi_arvalid_i,
  output logic                        s_axi_arready_o,
  input  wire logic [idw_pkg::IDW_AW-1:0] s_axi_araddr_i,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  output logic [31:0]                 s_axi_rdata_o,
  output logic [1:0]                  s_axi_rresp_o,
  input  wire logic                   hw_reset_i,
  input  wire logic                   identify_active_i,
  input  wire logic                   cable_detect_signal_i,
  input  wire logic                   count_exhausted_i,
  input  wire logic                   word_rd_i,
  input  wire logic [7:0]             word_idx_i,
  output logic [15:0]                 word_data_o,
  output logic                        word_valid_o,
  output logic                        security_abort_o
);
  // ==========================================
  // bus slave
  logic        aw_rdy_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        ar_rdy_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] cfg_ff [idw_pkg::IDW_NCFG];
  logic [2:0]  widx;
  logic [2:0]  ridx;
  logic        wr_do;
  logic        w_map;
  logic        r_map;
  logic [31:0] stat_word;

  assign widx  = s_axi_awaddr_i[4:2];
  assign ridx  = s_axi_araddr_i[4:2];
  assign wr_do = aw_rdy_ff;
  assign w_map = (s_axi_awaddr_i <= idw_pkg::IDW_OFF_STAT) && (widx != idw_pkg::IDW_STAT_IDX);
  assign r_map = s_axi_araddr_i <= idw_pkg::IDW_OFF_STAT;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction

  // address and data taken together, one write at a time
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_rdy_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= idw_pkg::IDW_RESP_OK;
    end else begin
      aw_rdy_ff <= s_axi_awvalid_i && s_axi_wvalid_i && !aw_rdy_ff && !bvalid_ff;
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= w_map ? idw_pkg::IDW_RESP_OK : idw_pkg::IDW_RESP_ERR;
      end else if (s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= idw_pkg::IDW_RESP_OK;
    end else begin
      ar_rdy_ff <= s_axi_arvalid_i && !ar_rdy_ff && !rvalid_ff;
      if (ar_rdy_ff) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= r_map ? idw_pkg::IDW_RESP_OK : idw_pkg::IDW_RESP_ERR;
        if (!r_map)
          rdata_ff <= 32'h00000000;
        else if (ridx == idw_pkg::IDW_STAT_IDX)
          rdata_ff <= stat_word;
        else
          rdata_ff <= cfg_ff[ridx];
      end else if (s_axi_rready_i) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // reserved bits masked at write so they read zero
  // R21: reserved bits zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < idw_pkg::IDW_NCFG; i++) cfg_ff[i] <= idw_pkg::IDW_CFG_RST;
    end else if (wr_do && w_map) begin
      cfg_ff[widx] <= wmerge(cfg_ff[widx], s_axi_wdata_i, s_axi_wstrb_i) & idw_pkg::IDW_CFG_MASK[widx];
    end
  end

  assign s_axi_awready_o = aw_rdy_ff;
  assign s_axi_wready_o  = aw_rdy_ff;
  assign s_axi_bvalid_o  = bvalid_ff;
  assign s_axi_bresp_o   = bresp_ff;
  assign s_axi_arready_o = ar_rdy_ff;
  assign s_axi_rvalid_o  = rvalid_ff;
  assign s_axi_rdata_o   = rdata_ff;
  assign s_axi_rresp_o   = rresp_ff;

  // ==========================================
  // configuration fields
  logic              dev1;
  logic              sig_en;
  logic              mwdma_en;
  logic              sel_en;
  logic [2:0]        sup_cnt;
  logic [2:0]        sel_mode;
  idw_pkg::idw_sec_t sec;
  logic [4:0]        sup;
  logic [4:0]        sel;

  assign dev1     = cfg_ff[0][idw_pkg::IDW_CTRL_DEV1];
  assign sig_en   = cfg_ff[0][idw_pkg::IDW_CTRL_SIG];
  assign mwdma_en = cfg_ff[0][idw_pkg::IDW_CTRL_MWDMA];
  assign sup_cnt  = cfg_ff[1][2:0];
  assign sel_mode = cfg_ff[1][6:4];
  assign sel_en   = cfg_ff[1][idw_pkg::IDW_UDMA_SELEN];
  assign sec      = idw_pkg::idw_sec_t'(cfg_ff[4][5:0]);

  // a mode is selectable only if supported, so bad software settings read as none
  for (genvar m = 0; m < idw_pkg::IDW_NUDMA; m++) begin : g_udma
    // R4: cumulative support
    assign sup[m] = sup_cnt > 3'(m);
    // R1: exclusive with multiword
    assign sel[m] = sel_en && !mwdma_en && sup[0] && sup[m] && (sel_mode == 3'(m));
  end

  // ==========================================
  // hardware test word, expired count
  logic [15:0] hwt_ff;
  logic        exp_ff;
  logic        hwt_chg;
  logic        exp_chg;

  assign hwt_chg = hw_reset_i || (identify_active_i && hwt_ff[idw_pkg::IDW_HWT_CBL] != cable_detect_signal_i);
  assign exp_chg = (count_exhausted_i && !exp_ff) || (hw_reset_i && exp_ff);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hwt_ff <= 16'h0000;
    end else if (hw_reset_i) begin
      // R10: results by device
      hwt_ff <= dev1 ? {2'b00, cfg_ff[6][5:0], 8'h00} : {8'h00, cfg_ff[6][7:0]};
    end else if (identify_active_i) begin
      // R11: cable level sample
      hwt_ff[idw_pkg::IDW_HWT_CBL] <= cable_detect_signal_i;
    end
  end

  // an exhaust event in the reset cycle wins, the count stays expired
  // R15: sticky until reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      exp_ff <= 1'b0;
    else if (count_exhausted_i)
      exp_ff <= 1'b1;
    else if (hw_reset_i)
      exp_ff <= 1'b0;
  end
  assign security_abort_o = exp_ff;

  // ==========================================
  // identify words
  logic [15:0] w_udma;
  logic [15:0] w_msn;
  logic [15:0] w_sec;
  logic [15:0] w_card;
  logic [15:0] w_integ;
  logic [7:0]  chk_ff;
  logic        csum_ok;

  // R2: one-hot selected
  // R3: reserved fields zero
  // R5: no support, no word
  assign w_udma = sup[0] ? {3'b000, sel, 3'b000, sup} : 16'h0000;
  // R12: media status word
  assign w_msn  = {14'h0000, 1'b0, cfg_ff[0][idw_pkg::IDW_CTRL_MSN]};
  // R13: maximum level only
  // R14: enhanced erase bit
  // R16: state bits
  assign w_sec  = {7'h00, sec.enabled && sec.max_lvl, 2'b00, sec.enh_erase, exp_ff,
                   sec.frozen, sec.locked, sec.enabled, sec.supported};
  // R17: card mode bits
  // R18: card current
  assign w_card = {2'b00, cfg_ff[5][13:0]};
  // R19: signature gates checksum
  assign w_integ = (sig_en && csum_ok) ? {chk_ff, idw_pkg::IDW_SIGNATURE} : 16'h0000;

  function automatic logic [15:0] word_at(input logic [7:0] i);
    logic [15:0] r;
    // R21: unlisted words zero
    r = 16'h0000;
    case (i)
      idw_pkg::IDW_W_UDMA:  r = w_udma;
      // R6: normal erase time
      idw_pkg::IDW_W_ERN:   r = {8'h00, cfg_ff[2][7:0]};
      // R7: enhanced erase time
      idw_pkg::IDW_W_ERE:   r = {8'h00, cfg_ff[2][15:8]};
      // R8: power level
      idw_pkg::IDW_W_APM:   r = {8'h00, cfg_ff[3][7:0]};
      // R9: revision code
      idw_pkg::IDW_W_MREV:  r = cfg_ff[3][31:16];
      idw_pkg::IDW_W_HWT:   r = hwt_ff;
      idw_pkg::IDW_W_MSN:   r = w_msn;
      idw_pkg::IDW_W_SEC:   r = w_sec;
      idw_pkg::IDW_W_CARD:  r = w_card;
      idw_pkg::IDW_W_INTEG: r = w_integ;
      default:              r = 16'h0000;
    endcase
    return r;
  endfunction

  // ==========================================
  // checksum engine
  idw_pkg::idw_cs_t cs_ff;
  logic [7:0]  idx_ff;
  logic [7:0]  sum_ff;
  logic        dirty_ff;
  logic [15:0] wc;
  logic [7:0]  acc_nxt;
  logic [7:0]  acc_total;

  // always_comb so the walk also sees word changes that arrive while the index stands still
  always_comb wc = word_at(idx_ff);
  assign acc_nxt   = 8'(sum_ff + wc[15:8] + wc[7:0]);
  assign acc_total = 8'(acc_nxt + idw_pkg::IDW_SIGNATURE);
  assign csum_ok   = (cs_ff == idw_pkg::IDW_CS_DONE) && !dirty_ff;

  // any change restarts the walk; a change during restart wins
  // R22: settle before sum
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      dirty_ff <= 1'b1;
    else if (wr_do || hwt_chg || exp_chg)
      dirty_ff <= 1'b1;
    else
      dirty_ff <= 1'b0;
  end

  // words 0..87 enter as a byte sum given by software
  // R20: negated byte sum
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_ff  <= idw_pkg::IDW_CS_IDLE;
      idx_ff <= idw_pkg::IDW_W_UDMA;
      sum_ff <= 8'h00;
      chk_ff <= 8'h00;
    end else if (dirty_ff) begin
      cs_ff  <= idw_pkg::IDW_CS_SUM;
      idx_ff <= idw_pkg::IDW_W_UDMA;
      sum_ff <= cfg_ff[6][15:8];
    end else begin
      case (cs_ff)
        idw_pkg::IDW_CS_SUM: begin
          sum_ff <= acc_nxt;
          idx_ff <= 8'(idx_ff + 8'h01);
          if (idx_ff == idw_pkg::IDW_W_LAST) begin
            chk_ff <= 8'(8'h00 - acc_total);
            cs_ff  <= idw_pkg::IDW_CS_DONE;
          end
        end
        idw_pkg::IDW_CS_DONE: cs_ff <= idw_pkg::IDW_CS_DONE;
        idw_pkg::IDW_CS_IDLE: cs_ff <= idw_pkg::IDW_CS_IDLE;
        default:              cs_ff <= idw_pkg::IDW_CS_IDLE;
      endcase
    end
  end

  assign stat_word = {hwt_ff, 6'h00, exp_ff, csum_ok, chk_ff};

  // ==========================================
  // word read port for the host adapter
  logic [15:0] wdata_ff;
  logic        wvalid_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wdata_ff  <= 16'h0000;
      wvalid_ff <= 1'b0;
    end else begin
      wvalid_ff <= word_rd_i;
      if (word_rd_i) wdata_ff <= word_at(word_idx_i);
    end
  end
  assign word_data_o  = wdata_ff;
  assign word_valid_o = wvalid_ff;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_udma_onehot;
    $onehot0(w_udma[12:8]) && (w_udma[15:13] == 3'b000) && (w_udma[7:5] == 3'b000);
  endproperty
  a_udma_onehot: assert property (p_udma_onehot) else $error("udma selected not one-hot"); // R2
  property p_mwdma_excl;
    mwdma_en |-> (w_udma[12:8] == 5'h00);
  endproperty
  a_mwdma_excl: assert property (p_mwdma_excl) else $error("udma selected with multiword"); // R1
  property p_sup_run;
    (8'(w_udma[4:0]) & 8'(w_udma[4:0] + 5'h01)) == 8'h00;
  endproperty
  a_sup_run: assert property (p_sup_run) else $error("supported bits not contiguous"); // R4
  property p_no_udma;
    !w_udma[0] |-> (w_udma == 16'h0000);
  endproperty
  a_no_udma: assert property (p_no_udma) else $error("udma word nonzero without mode 0"); // R5
  property p_hwt_dev0;
    (hw_reset_i && !dev1) |=> (hwt_ff[15:8] == 8'h00) && (hwt_ff[7:0] == $past(cfg_ff[6][7:0]));
  endproperty
  a_hwt_dev0: assert property (p_hwt_dev0) else $error("device 0 reset result misplaced"); // R10
  property p_cable;
    (identify_active_i && !hw_reset_i) |=> hwt_ff[13] == $past(cable_detect_signal_i);
  endproperty
  a_cable: assert property (p_cable) else $error("cable level not sampled"); // R11
  sequence s_exhaust;
    count_exhausted_i ##1 !hw_reset_i [*2];
  endsequence
  property p_expired;
    s_exhaust |-> exp_ff && security_abort_o && w_sec[4];
  endproperty
  a_expired: assert property (p_expired) else $error("expired count lost"); // R15
  property p_sec_lvl;
    (word_valid_o && ($past(word_idx_i) == idw_pkg::IDW_W_SEC)) |->
      (word_data_o[8] == (word_data_o[1] && $past(sec.max_lvl)));
  endproperty
  a_sec_lvl: assert property (p_sec_lvl) else $error("security level bit wrong"); // R13
  property p_msn;
    w_msn[15:1] == 15'h0000;
  endproperty
  a_msn: assert property (p_msn) else $error("media status reserved bits set"); // R12
  sequence s_last_word;
    (cs_ff == idw_pkg::IDW_CS_SUM) && !dirty_ff && (idx_ff == idw_pkg::IDW_W_LAST);
  endsequence
  property p_chk;
    s_last_word |=> (8'(chk_ff + $past(acc_total)) == 8'h00) && (cs_ff == idw_pkg::IDW_CS_DONE);
  endproperty
  a_chk: assert property (p_chk) else $error("checksum does not zero the sum"); // R20
  property p_settle;
    dirty_ff |=> !csum_ok ##0 (cs_ff == idw_pkg::IDW_CS_SUM) || dirty_ff;
  endproperty
  a_settle: assert property (p_settle) else $error("checksum valid while words change"); // R22
endmodule

// *** idw_host_model.sv ***
module idw_host_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  output logic             word_rd_o,
  output logic [7:0]       word_idx_o,
  input  wire logic [15:0] word_data_i,
  input  wire logic        word_valid_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    word_rd_o = 1'b0;
    word_idx_o = 8'h00;
  end

  // ==========================================
  // single word read, index held one edge only
  task automatic read_word(input logic [7:0] i, output logic [15:0] d, output logic ok);
    int n;
    @(posedge clk_i);
    word_rd_o <= 1'b1;
    word_idx_o <= i;
    @(posedge clk_i);
    word_rd_o <= 1'b0;
    // released index no longer shows the last value
    word_idx_o <= ~i;
    n = 0;
    ok = 1'b0;
    while (n < 20 && !ok) begin
      @(posedge clk_i);
      n++;
      if (word_valid_i === 1'b1) ok = 1'b1;
    end
    d = word_data_i;
  endtask

  // ==========================================
  // whole block read, bytes summed mod 256
  // host validates checksum
  task automatic sum_all(output logic [7:0] s, output logic [15:0] w255);
    logic [15:0] d;
    logic        ok;
    s = 8'h00;
    for (int i = 0; i < 256; i++) begin
      read_word(i[7:0], d, ok);
      if (!ok) d = 16'hFFFF;
      s = s + d[15:8] + d[7:0];
    end
    w255 = d;
  endtask
endmodule

// *** idw_top_tb.sv ***
module idw_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_i, rstn_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, word_valid, abort;
  logic        hw_reset, idf, cable, exhaust, word_rd;
  logic [7:0]  awaddr, araddr, word_idx, s;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] word_data, d;
  logic        ok;
  int          fails, n_tests;

  // addr, write data, word index, expected word
  localparam logic [63:0] ROWS [17] = '{
    64'h04_00000093_58_0207, 64'h00_00000006_58_0007, 64'h00_00000002_58_0207,
    64'h04_000000C7_58_101F, 64'h04_00000090_58_0000, 64'h04_00000093_58_0207,
    64'h08_000001FF_59_00FF, 64'h08_000001FF_5A_0001, 64'h0C_FFFE0080_5B_0080,
    64'h0C_FFFE0080_5C_FFFE, 64'h10_00000033_80_0123, 64'h10_00000027_80_0027,
    64'h10_00000011_80_0001, 64'h14_00003ABC_A0_3ABC, 64'h00_0000000A_7F_0001,
    64'h00_00000002_7F_0000, 64'h00_00000002_64_0000};

  idw_top u_idw_top (
    .clk_i(clk_i), .rstn_i(rstn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .hw_reset_i(hw_reset),
    .identify_active_i(idf), .cable_detect_signal_i(cable), .count_exhausted_i(exhaust),
    .word_rd_i(word_rd), .word_idx_i(word_idx), .word_data_o(word_data),
    .word_valid_o(word_valid), .security_abort_o(abort));

  idw_host_model u_idw_host_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .word_rd_o(word_rd), .word_idx_o(word_idx),
    .word_data_i(word_data), .word_valid_i(word_valid));

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] r);
    int n;
    logic ad, wd;
    @(posedge clk_i);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= dt;
    bready <= 1'b1;
    {n, ad, wd} = '0;
    // each channel released at its own ready
    while (!(ad && wd) && n < 50) begin
      @(posedge clk_i);
      n++;
      if (awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do begin @(posedge clk_i); n++; end while (bvalid !== 1'b1 && n < 100);
    bready <= 1'b0;
    if (bvalid !== 1'b1) fails++;
    chk(bresp, r);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge clk_i); n++; end while (rvalid !== 1'b1 && n < 100);
    rready <= 1'b0;
    if (rvalid !== 1'b1) fails++;
    chk(rdata, e);
    chk(rresp, r);
  endtask

  task automatic word(input logic [7:0] i, input logic [15:0] e);
    u_idw_host_model.read_word(i, d, ok);
    chk({15'h0, ok, d}, {16'h1, e});
  endtask

  task automatic pulse_hw();
    @(posedge clk_i);
    hw_reset <= 1'b1;
    @(posedge clk_i);
    hw_reset <= 1'b0;
  endtask

  // ==========================================
  // clock, watchdog, stimulus
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #60us;
    fails++;
    final_report();
  end

  initial begin
    {rstn_i, awvalid, wvalid, bready, arvalid, rready, hw_reset, idf, cable, exhaust} = '0;
    {awaddr, araddr, wdata, fails, n_tests} = '0;
    wstrb = 4'hF;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    axr(8'h00, 32'h0, 2'h0);
    axr(8'h20, 32'h0, 2'h2);
    axw(8'h1C, 32'hFFFFFFFF, 2'h2);
    axw(8'h04, 32'hFFFFFFFF, 2'h0);
    axr(8'h04, 32'h000000F7, 2'h0);
    axw(8'h00, 32'h2, 2'h0);
    axw(8'h18, 32'h5A, 2'h0);
    foreach (ROWS[i]) begin
      axw(ROWS[i][63:56], ROWS[i][55:24], 2'h0);
      word(ROWS[i][23:16], ROWS[i][15:0]);
    end
    axr(8'h0C, 32'hFFFE0080, 2'h0);
    // expired count aborts until hardware reset
    @(posedge clk_i);
    exhaust <= 1'b1;
    @(posedge clk_i);
    exhaust <= 1'b0;
    word(8'h80, 16'h0011);
    chk(abort, 1'b1);
    pulse_hw();
    word(8'h80, 16'h0001);
    chk(abort, 1'b0);
    word(8'h5D, 16'h005A);
    axw(8'h00, 32'h3, 2'h0);
    pulse_hw();
    word(8'h5D, 16'h1A00);
    idf <= 1'b1;
    cable <= 1'b1;
    repeat (3) @(posedge clk_i);
    word(8'h5D, 16'h3A00);
    cable <= 1'b0;
    repeat (3) @(posedge clk_i);
    word(8'h5D, 16'h1A00);
    idf <= 1'b0;
    axw(8'h00, 32'h2, 2'h0);
    pulse_hw();
    word(8'hFF, 16'h0000);
    repeat (200) @(posedge clk_i);
    u_idw_host_model.sum_all(s, d);
    chk(s, 8'h00);
    chk(d[7:0], 8'hA5);
    axw(8'h00, 32'h0, 2'h0);
    repeat (200) @(posedge clk_i);
    word(8'hFF, 16'h0000);
    // exhaust and hardware reset in one cycle: the exhaust wins
    @(posedge clk_i);
    exhaust <= 1'b1;
    hw_reset <= 1'b1;
    @(posedge clk_i);
    exhaust <= 1'b0;
    hw_reset <= 1'b0;
    @(posedge clk_i);
    chk(abort, 1'b1);
    // power-on reset in mid-run clears the expired count and the config
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk(abort, 1'b0);
    axr(8'h1C, 32'h00000000, 2'h0);
    axr(8'h04, 32'h00000000, 2'h0);
    word(8'h58, 16'h0000);
    final_report();
  end
endmodule
